// *** design/bsf_consts.vh ***
// Constants for the boot serial flash sequencer
`ifndef BSF_CONSTS_VH
`define BSF_CONSTS_VH

// ------------------------------------------------------------------
// Flash opcodes and status layout
// ------------------------------------------------------------------
`define BSF_OPC_WRITE_ENABLE 8'h06
`define BSF_OPC_STATUS_READ 8'h05
`define BSF_OPC_STATUS_WRITE 8'h01
`define BSF_OPC_FAST_READ 8'h0b
`define BSF_OPC_PAGE_PROG 8'h02
`define BSF_OPC_SECTOR_ERASE 8'h20
`define BSF_OPC_CHIP_ERASE 8'hc7
`define BSF_STATUS_CLEAR 8'h00
`define BSF_FILL_BYTE 8'h00
`define BSF_BIT_BUSY 0
`define BSF_BIT_WLATCH 1

// ------------------------------------------------------------------
// Command port operation codes
// ------------------------------------------------------------------
`define BSF_OP_READ 2'h0
`define BSF_OP_PROG 2'h1
`define BSF_OP_SECTOR 2'h2
`define BSF_OP_CHIP 2'h3

// ------------------------------------------------------------------
// Timing: 20 MHz system clock, serial clock is a fixed division
// ------------------------------------------------------------------
`define BSF_CLK_MHZ 20
`define BSF_SCK_DIV 8
`define BSF_SCK_HALF 4
`define BSF_T_CSH_NS 200
`define BSF_CSH_CYC ((`BSF_T_CSH_NS * `BSF_CLK_MHZ + 999) / 1000)

// ------------------------------------------------------------------
// Read data buffer shape
// ------------------------------------------------------------------
`define BSF_FIFO_WIDTH 8
`define BSF_FIFO_DEPTH 8
`define BSF_FIFO_AW 3

`endif

// *** design/bsf_fifo.v ***
// Synchronous FIFO with a registered output stage
`timescale 1ns/10ps
`default_nettype none

module bsf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire i_clk,
    input wire i_rst,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output reg o_out_valid,
    input wire i_out_ready,
    output reg [WIDTH-1:0] o_out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr;
    reg [AW-1:0] rptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    // ------------------------------------------------------------------
    // Handshake terms
    // ------------------------------------------------------------------
    assign o_in_ready = (count < DEPTH[AW:0]);
    assign push = i_in_valid & o_in_ready;
    // Refill the output register when it is empty or being taken
    assign pop = (count != {(AW+1){1'b0}}) & (~o_out_valid | i_out_ready);

    // Storage array, no reset needed on the data
    always @(posedge i_clk) begin
        if (push) begin
            mem[wptr] <= i_in_data;
        end
    end

    // Pointers, fill level and output stage
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wptr <= {AW{1'b0}};
            rptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            o_out_valid <= 1'b0;
            o_out_data <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
                o_out_data <= mem[rptr];
                o_out_valid <= 1'b1;
            end else if (i_out_ready) begin
                o_out_valid <= 1'b0;
            end
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

endmodule

`default_nettype wire

// *** design/bsf_seq.v ***
// Boot serial flash sequencer: unprotect, write-enable gating, commands
// ------------------------------------------------------------------
// Notes on behaviour
// - Assume protection on; always clear at boot
// - Boot: enable, poll latch, write status zero
// - Enable and latch poll before program, erase
// - One fixed protocol and serial clock rate
// - Fast read: opcode, address, dummy, data
// - Status write carries exactly one byte
// - Page program: opcode, address, data run
// - Sector erase with address; chip erase alone
// - Pause and write-guard pins never driven
// - Reset tri-states clock, data, primary select
// - Program commands accepted with valid firmware
// - Single-width transfers in mode 0
// - Boot and reads use primary select only
// ------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "bsf_consts.vh"

module bsf_seq (
    input wire I_CLK_SYS,
    input wire I_SYS_RST,
    input wire I_FW_VALID,
    input wire I_CMD_VALID,
    input wire [1:0] I_CMD_OP,
    input wire [23:0] I_CMD_ADDR,
    input wire [15:0] I_CMD_LEN,
    output reg O_CMD_READY,
    input wire I_WR_VALID,
    input wire [7:0] I_WR_DATA,
    output reg O_WR_READY,
    output wire O_RD_VALID,
    output wire [7:0] O_RD_DATA,
    input wire I_RD_READY,
    output reg O_BOOT_DONE,
    output reg O_BUSY,
    output wire O_FLASH_SERIAL_CLOCK,
    output reg O_FLASH_SERIAL_CLOCK_OE,
    output wire O_FLASH_SERIAL_OUT,
    output reg O_FLASH_SERIAL_OUT_OE,
    input wire I_FLASH_SERIAL_IN,
    output reg O_FLASH_SELECT_PRIMARY_N,
    output reg O_FLASH_SELECT_PRIMARY_N_OE,
    output reg O_FLASH_SELECT_SECONDARY_N
);

    // Sequencer states
    localparam ST_IDLE = 2'h0;
    localparam ST_NEXT = 2'h1;
    localparam ST_XFER = 2'h2;
    localparam ST_GAP = 2'h3;
    // Instruction being sent
    localparam IN_WEN = 3'h0;
    localparam IN_POLL_LATCH = 3'h1;
    localparam IN_STAT_WR = 3'h2;
    localparam IN_OP = 3'h3;
    localparam IN_POLL_BUSY = 3'h4;

    reg [1:0] st;
    reg [2:0] ins;
    reg [16:0] idx;
    reg [16:0] len_b;
    reg [7:0] stat;
    reg [1:0] op;
    reg [23:0] addr;
    reg [15:0] dlen;
    reg booting;
    reg [2:0] gap;
    reg [7:0] wbuf;
    reg have_w;
    reg [7:0] tx;
    reg start;
    reg miso_s1;
    reg miso_s2;
    wire sh_done;
    wire sh_busy;
    wire [7:0] sh_rx;
    wire fifo_ready;
    wire need_w;
    wire rd_data_byte;
    wire can_go;

    // ------------------------------------------------------------------
    // Input synchroniser for the flash data line
    // ------------------------------------------------------------------
    always @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            miso_s1 <= 1'b0;
            miso_s2 <= 1'b0;
        end else begin
            miso_s1 <= I_FLASH_SERIAL_IN;
            miso_s2 <= miso_s1;
        end
    end

    bsf_shift u_shift (
        .i_clk(I_CLK_SYS),
        .i_rst(I_SYS_RST),
        .i_start(start),
        .i_tx(tx),
        .i_miso(miso_s2),
        .o_sck(O_FLASH_SERIAL_CLOCK),
        .o_mosi(O_FLASH_SERIAL_OUT),
        .o_done(sh_done),
        .o_rx(sh_rx),
        .o_busy(sh_busy)
    );

    // Read data path; a full buffer stalls the next read byte
    bsf_fifo #(
        .WIDTH(`BSF_FIFO_WIDTH),
        .DEPTH(`BSF_FIFO_DEPTH),
        .AW(`BSF_FIFO_AW)
    ) u_fifo (
        .i_clk(I_CLK_SYS),
        .i_rst(I_SYS_RST),
        .i_in_valid(sh_done & rd_data_byte),
        .o_in_ready(fifo_ready),
        .i_in_data(sh_rx),
        .o_out_valid(O_RD_VALID),
        .i_out_ready(I_RD_READY),
        .o_out_data(O_RD_DATA)
    );

    // ------------------------------------------------------------------
    // Byte classification
    // ------------------------------------------------------------------
    // bytes after the address of a program come from the write port
    assign need_w = (ins == IN_OP) & (op == `BSF_OP_PROG) & (idx >= 17'd4);
    // bytes after the dummy of a fast read go to the buffer
    assign rd_data_byte = (ins == IN_OP) & (op == `BSF_OP_READ) & (idx >= 17'd5);
    // Room is checked before a byte starts; only one byte is ever in flight
    assign can_go = need_w ? have_w : (rd_data_byte ? fifo_ready : 1'b1);

    // Instruction length in bytes
    always @* begin
        case (ins)
            IN_WEN: len_b = 17'd1;
            // one status byte only; polls are opcode plus reply
            IN_POLL_LATCH, IN_POLL_BUSY, IN_STAT_WR: len_b = 17'd2;
            default: begin
                case (op)
                    `BSF_OP_READ: len_b = 17'd5 + {1'b0, dlen};
                    `BSF_OP_PROG: len_b = 17'd4 + {1'b0, dlen};
                    // sector erase has an address, chip erase has none
                    `BSF_OP_SECTOR: len_b = 17'd4;
                    default: len_b = 17'd1;
                endcase
            end
        endcase
    end

    // Byte to shift out for the current position
    always @* begin
        tx = `BSF_FILL_BYTE;
        case (ins)
            IN_WEN: tx = `BSF_OPC_WRITE_ENABLE;
            IN_POLL_LATCH, IN_POLL_BUSY: begin
                if (idx == 17'd0) begin
                    tx = `BSF_OPC_STATUS_READ;
                end
            end
            IN_STAT_WR: begin
                tx = (idx == 17'd0) ? `BSF_OPC_STATUS_WRITE : `BSF_STATUS_CLEAR;
            end
            default: begin
                if (idx == 17'd0) begin
                    case (op)
                        `BSF_OP_READ: tx = `BSF_OPC_FAST_READ;
                        `BSF_OP_PROG: tx = `BSF_OPC_PAGE_PROG;
                        `BSF_OP_SECTOR: tx = `BSF_OPC_SECTOR_ERASE;
                        default: tx = `BSF_OPC_CHIP_ERASE;
                    endcase
                end else if (idx < 17'd4) begin
                    tx = addr[8 * (3 - idx[1:0]) +: 8]; // High byte first
                end else if (need_w) begin
                    tx = wbuf;
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Instruction sequencer
    // ------------------------------------------------------------------
    // Start is a register so the shifter sees a clean single-cycle request
    always @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            st <= ST_IDLE;
            // boot always begins by clearing protection
            ins <= IN_WEN;
            booting <= 1'b1;
            idx <= 17'd0;
            stat <= 8'h00;
            op <= `BSF_OP_READ;
            addr <= 24'h000000;
            dlen <= 16'h0000;
            gap <= 3'h0;
            wbuf <= 8'h00;
            have_w <= 1'b0;
            start <= 1'b0;
            O_WR_READY <= 1'b0;
            O_CMD_READY <= 1'b0;
            O_BOOT_DONE <= 1'b0;
            O_BUSY <= 1'b1;
            O_FLASH_SELECT_PRIMARY_N <= 1'b1;
        end else begin
            start <= 1'b0;
            // Write port handshake for program data
            if (I_WR_VALID & O_WR_READY) begin
                wbuf <= I_WR_DATA;
                have_w <= 1'b1;
                O_WR_READY <= 1'b0;
            end
            case (st)
                ST_IDLE: begin
                    if (booting) begin
                        // boot unprotect begins with write enable
                        ins <= IN_WEN;
                        st <= ST_NEXT;
                    end else if (I_CMD_VALID & O_CMD_READY) begin
                        O_CMD_READY <= 1'b0;
                        O_BUSY <= 1'b1;
                        op <= I_CMD_OP;
                        addr <= I_CMD_ADDR;
                        dlen <= I_CMD_LEN;
                        idx <= 17'd0;
                        // program or erase first needs write enable
                        ins <= (I_CMD_OP == `BSF_OP_READ) ? IN_OP : IN_WEN;
                        st <= ST_NEXT;
                    end else begin
                        O_CMD_READY <= I_FW_VALID;
                        O_BUSY <= 1'b0;
                    end
                end
                ST_NEXT: begin
                    if (idx == 17'd0) begin
                        // every access uses the primary select
                        O_FLASH_SELECT_PRIMARY_N <= 1'b0;
                    end
                    if (need_w & ~have_w & ~O_WR_READY) begin
                        O_WR_READY <= 1'b1;
                    end
                    if (can_go & ~sh_busy) begin
                        start <= 1'b1;
                        if (need_w) begin
                            have_w <= 1'b0;
                        end
                        st <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (sh_done) begin
                        if (idx == 17'd1) begin
                            stat <= sh_rx;
                        end
                        if (idx + 17'd1 == len_b) begin
                            O_FLASH_SELECT_PRIMARY_N <= 1'b1;
                            gap <= 3'h0;
                            st <= ST_GAP;
                        end else begin
                            idx <= idx + 17'd1;
                            st <= ST_NEXT;
                        end
                    end
                end
                ST_GAP: begin
                    // Select high time, then choose the next instruction
                    gap <= gap + 3'h1;
                    if ({29'h0, gap} == (`BSF_CSH_CYC - 1)) begin
                        idx <= 17'd0;
                        st <= ST_NEXT;
                        case (ins)
                            IN_WEN: ins <= IN_POLL_LATCH;
                            IN_POLL_LATCH: begin
                                // wait for the write latch before acting
                                if (stat[`BSF_BIT_WLATCH]) begin
                                    ins <= booting ? IN_STAT_WR : IN_OP;
                                end
                            end
                            IN_STAT_WR: ins <= IN_POLL_BUSY;
                            IN_OP: begin
                                if (op == `BSF_OP_READ) begin
                                    st <= ST_IDLE;
                                end else begin
                                    ins <= IN_POLL_BUSY;
                                end
                            end
                            default: begin
                                // Hold off further work while the flash is busy
                                if (~stat[`BSF_BIT_BUSY]) begin
                                    st <= ST_IDLE;
                                    booting <= 1'b0;
                                    O_BOOT_DONE <= 1'b1;
                                end
                            end
                        endcase
                    end
                end
                default: st <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pin drive enables
    // ------------------------------------------------------------------
    // reset releases clock, data and primary select to the board
    // pause and write-guard pins have no outputs here at all
    // Secondary select is held high and keeps driving through reset
    always @(posedge I_CLK_SYS or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_FLASH_SERIAL_CLOCK_OE <= 1'b0;
            O_FLASH_SERIAL_OUT_OE <= 1'b0;
            O_FLASH_SELECT_PRIMARY_N_OE <= 1'b0;
            O_FLASH_SELECT_SECONDARY_N <= 1'b1;
        end else begin
            O_FLASH_SERIAL_CLOCK_OE <= 1'b1;
            O_FLASH_SERIAL_OUT_OE <= 1'b1;
            O_FLASH_SELECT_PRIMARY_N_OE <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// *** design/bsf_shift.v ***
// Mode 0 byte shifter with a divided serial clock
`timescale 1ns/10ps
`default_nettype none
`include "bsf_consts.vh"

module bsf_shift (
    input wire i_clk,
    input wire i_rst,
    input wire i_start,
    input wire [7:0] i_tx,
    input wire i_miso,
    output reg o_sck,
    output wire o_mosi,
    output reg o_done,
    output reg [7:0] o_rx,
    output reg o_busy
);

    reg [7:0] sh;
    reg [2:0] bits;
    reg [3:0] cnt;

    // Data leads from the top bit; changes only while the clock is low
    assign o_mosi = sh[7];

    // ------------------------------------------------------------------
    // Bit engine: rise at half period, sample and fall at period end
    // ------------------------------------------------------------------
    // Sampling late in the high phase leaves room for the input synchroniser
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sh <= 8'h00;
            bits <= 3'h0;
            cnt <= 4'h0;
            o_sck <= 1'b0;
            o_done <= 1'b0;
            o_rx <= 8'h00;
            o_busy <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start & ~o_busy) begin
                o_busy <= 1'b1;
                sh <= i_tx;
                bits <= 3'h0;
                cnt <= 4'h0;
                o_sck <= 1'b0;
            end else if (o_busy) begin
                cnt <= cnt + 4'h1;
                if ({28'h0, cnt} == (`BSF_SCK_HALF - 1)) begin
                    o_sck <= 1'b1;
                end
                if ({28'h0, cnt} == (`BSF_SCK_DIV - 1)) begin
                    o_sck <= 1'b0;
                    cnt <= 4'h0;
                    o_rx <= {o_rx[6:0], i_miso};
                    sh <= {sh[6:0], 1'b0};
                    bits <= bits + 3'h1;
                    if (bits == 3'h7) begin
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** testbench/bsf_flash_model.sv ***
// Behavioural single-width serial flash facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module bsf_flash_model (
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso
);
    // Protection bits start set; the sequencer must clear them
    logic [7:0] sr, op, st = 8'h1c, tx, lop, pdat;
    logic [23:0] addr;
    logic pend = 1'h0;
    int nbit, nb, lnb, n_we = 0, n_bad = 0;
    initial o_miso = 1'h0;
    // Frame edges; a released output shows the inverse of its last bit
    always @(i_cs_n) begin
        if (i_cs_n && op != 8'h05) begin
            lop = op;
            lnb = nb;
        end
        if (i_cs_n && (op == 8'h01 || op == 8'h02 || op == 8'h20 || op == 8'hc7)) st[0] = 1'h1;
        nbit = 0;
        nb = 0;
        o_miso = ~o_miso;
    end
    // any clock rate
    // Byte decode on the rising clock, mode 0
    always @(posedge i_sck) if (!i_cs_n) begin
        sr = {sr[6:0], i_mosi};
        nbit++;
        if (nbit == 8) begin
            nbit = 0;
            if (nb == 0) op = sr;
            if (nb == 0 && op == 8'h06) pend = 1'h1;
            n_we += (nb == 0 && op == 8'h06);
            if (nb == 0 && (op == 8'h02 || op == 8'h20 || op == 8'hc7)) begin
                if (!st[1]) n_bad++;
                st[1] = 1'h0;
            end
            if (nb >= 1 && nb <= 3 && op != 8'h01 && op != 8'h05) addr = {addr[15:0], sr};
            if (op == 8'h01 && nb == 1) st = sr;
            if (op == 8'h01 && nb > 1) n_bad++;
            if (op == 8'h02 && nb > 3) pdat = sr;
            tx = (op == 8'h0b) ? 8'(160 + nb - 4) : st;
            // Latch shows only on the poll after it, so polling must repeat
            if (op == 8'h05) begin
                st[0] = 1'h0;
                if (pend) st[1] = 1'h1;
                pend = 1'h0;
            end
            nb++;
        end
    end
    // Output changes on the falling clock
    always @(negedge i_sck) if (!i_cs_n) begin
        o_miso = tx[7];
        tx = tx << 1;
    end
endmodule
`default_nettype wire

// *** testbench/bsf_seq_asserts.sv ***
// Port checker for the boot serial flash sequencer
`timescale 1ns/10ps
`default_nettype none
module bsf_seq_asserts (
    input wire logic I_CLK_SYS,
    input wire logic I_SYS_RST,
    input wire logic I_FW_VALID,
    input wire logic I_CMD_VALID,
    input wire logic O_CMD_READY,
    input wire logic I_WR_VALID,
    input wire logic O_WR_READY,
    input wire logic O_RD_VALID,
    input wire logic [7:0] O_RD_DATA,
    input wire logic I_RD_READY,
    input wire logic O_BOOT_DONE,
    input wire logic O_BUSY,
    input wire logic O_FLASH_SERIAL_CLOCK,
    input wire logic O_FLASH_SERIAL_CLOCK_OE,
    input wire logic O_FLASH_SERIAL_OUT,
    input wire logic O_FLASH_SERIAL_OUT_OE,
    input wire logic O_FLASH_SELECT_PRIMARY_N,
    input wire logic O_FLASH_SELECT_PRIMARY_N_OE,
    input wire logic O_FLASH_SELECT_SECONDARY_N
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST);
    // ------------------------------------------------------------
    // Serial link shape
    // ------------------------------------------------------------
    sequence s_cs_gap;
        O_FLASH_SELECT_PRIMARY_N [*4];
    endsequence
    sequence s_sck_high;
        O_FLASH_SERIAL_CLOCK [*4] ##1 !O_FLASH_SERIAL_CLOCK;
    endsequence
    // Reset is checked while it is active, so it cannot disable itself
    property p_oe_rst;
        disable iff (1'h0) I_SYS_RST |-> !O_FLASH_SERIAL_CLOCK_OE && !O_FLASH_SERIAL_OUT_OE
            && !O_FLASH_SELECT_PRIMARY_N_OE && O_FLASH_SELECT_SECONDARY_N;
    endproperty
    property p_cs_gap;
        $rose(O_FLASH_SELECT_PRIMARY_N) |-> s_cs_gap;
    endproperty
    property p_sck_rate;
        $rose(O_FLASH_SERIAL_CLOCK) |-> s_sck_high;
    endproperty
    property p_sck_idle;
        O_FLASH_SELECT_PRIMARY_N |-> !O_FLASH_SERIAL_CLOCK;
    endproperty
    property p_out_hold;
        O_FLASH_SERIAL_CLOCK && $past(O_FLASH_SERIAL_CLOCK) |-> $stable(O_FLASH_SERIAL_OUT);
    endproperty
    property p_sec_idle;
        O_FLASH_SELECT_SECONDARY_N;
    endproperty
    // ------------------------------------------------------------
    // User side handshakes
    // ------------------------------------------------------------
    property p_fw_gate;
        (!I_FW_VALID ##1 !I_FW_VALID) or !O_BOOT_DONE |-> !O_CMD_READY;
    endproperty
    property p_take;
        I_CMD_VALID && O_CMD_READY |=> !O_CMD_READY && O_BUSY;
    endproperty
    property p_wr_take;
        I_WR_VALID && O_WR_READY |=> !O_WR_READY;
    endproperty
    property p_rd_hold;
        O_RD_VALID && !I_RD_READY |=> O_RD_VALID && $stable(O_RD_DATA);
    endproperty
    a_oe_rst: assert property (p_oe_rst) else $error("pins driven in reset");
    a_cs_gap: assert property (p_cs_gap) else $error("select gap short");
    a_sck_rate: assert property (p_sck_rate) else $error("clock high time wrong");
    a_sck_idle: assert property (p_sck_idle) else $error("clock not idle low");
    a_out_hold: assert property (p_out_hold) else $error("out moved in high");
    a_sec_idle: assert property (p_sec_idle) else $error("second select used");
    a_fw_gate: assert property (p_fw_gate) else $error("ready without firmware");
    a_take: assert property (p_take) else $error("command take wrong");
    a_wr_take: assert property (p_wr_take) else $error("write ready held");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the boot serial flash sequencer
`timescale 1ns/10ps
`default_nettype none
`include "bsf_consts.vh"
module tb_top;
    logic clk = 1'h0, rst = 1'h0, fw = 1'h0, cv = 1'h0, wv = 1'h0, rr = 1'h1;
    logic [1:0] op = 2'h0;
    logic [23:0] ad = 24'h0;
    logic [15:0] ln = 16'h0;
    logic [7:0] wd = 8'h00;
    wire cr, wr, rv, bd, bs, sck, sck_oe, so, so_oe, cs, cs_oe, cs2, miso;
    wire [7:0] rd;
    logic [7:0] wq[$], rq[$];
    int err_total = 0, checks = 0, i;
    // released pins pulled for a programmer
    wire f_sck = sck_oe ? sck : 1'h0;
    wire f_so = so_oe ? so : 1'h1;
    wire f_cs = cs_oe ? cs : 1'h1;
    // 20 MHz system clock
    always #25 clk = ~clk;
    bsf_seq dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_FW_VALID(fw), .I_CMD_VALID(cv),
        .I_CMD_OP(op), .I_CMD_ADDR(ad), .I_CMD_LEN(ln), .O_CMD_READY(cr), .I_WR_VALID(wv),
        .I_WR_DATA(wd), .O_WR_READY(wr), .O_RD_VALID(rv), .O_RD_DATA(rd), .I_RD_READY(rr),
        .O_BOOT_DONE(bd), .O_BUSY(bs), .O_FLASH_SERIAL_CLOCK(sck),
        .O_FLASH_SERIAL_CLOCK_OE(sck_oe), .O_FLASH_SERIAL_OUT(so),
        .O_FLASH_SERIAL_OUT_OE(so_oe), .I_FLASH_SERIAL_IN(miso),
        .O_FLASH_SELECT_PRIMARY_N(cs), .O_FLASH_SELECT_PRIMARY_N_OE(cs_oe),
        .O_FLASH_SELECT_SECONDARY_N(cs2));
    bsf_flash_model flash (.i_sck(f_sck), .i_cs_n(f_cs), .i_mosi(f_so), .o_miso(miso));
    // Program data offer from a queue; read data capture
    always @(posedge clk) begin
        if (wv && wr === 1'h1) wq.delete(0);
        wv <= (wq.size() != 0);
        wd <= (wq.size() != 0) ? wq[0] : 8'h00;
        if (rv === 1'h1 && rr) rq.push_back(rd);
    end
    task automatic cmp(input string nm, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    // One command: wait for ready, hold the request one edge, wait for idle
    task automatic cmd(input logic [1:0] o, input logic [23:0] a, input logic [15:0] l);
        int k;
        for (k = 0; k < 20000 && cr !== 1'h1; k++) @(posedge clk);
        cv <= 1'h1;
        op <= o;
        ad <= a;
        ln <= l;
        @(posedge clk);
        cv <= 1'h0;
        repeat (2) @(posedge clk);
        for (k = 0; k < 20000 && bs !== 1'h0; k++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask
    task automatic results;
        if (err_total == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial begin
        // A real edge at time zero clears the flops before the first clock
        rst <= 1'h1;
        repeat (3) @(posedge clk);
        cmp("oe_rst", 24'h1, {~sck_oe, ~so_oe, ~cs_oe} == 3'h7 && cs2);
        rst <= 1'h0;
        for (i = 0; i < 20000 && bd !== 1'h1; i++) @(posedge clk);
        repeat (30) @(posedge clk);
        cmp("oe_run", 24'h7, {sck_oe, so_oe, cs_oe});
        cmp("status", 24'h0, flash.st);
        cmp("boot_wen", 24'h1, flash.n_we);
        cmp("boot_op", 24'h01, flash.lop);
        cmp("wsr_len", 24'h2, flash.lnb);
        cmp("no_fw", 24'h0, cr);
        fw <= 1'h1;
        cmd(`BSF_OP_SECTOR, 24'h123456, 16'h0);
        cmp("er_op", 24'h20, flash.lop);
        cmp("er_adr", 24'h123456, flash.addr);
        cmp("er_wen", 24'h2, flash.n_we);
        wq = '{8'h5a, 8'hc3};
        cmd(`BSF_OP_PROG, 24'h000100, 16'h2);
        cmp("pp_op", 24'h02, flash.lop);
        cmp("pp_len", 24'h6, flash.lnb);
        cmp("pp_dat", 24'hc3, flash.pdat);
        cmd(`BSF_OP_CHIP, 24'h0, 16'h0);
        cmp("ce_op", 24'hc7, flash.lop);
        cmp("ce_len", 24'h1, flash.lnb);
        cmp("wen_all", 24'h4, flash.n_we);
        cmp("wen_order", 24'h0, flash.n_bad);
        rr <= 1'h0;
        fork
            cmd(`BSF_OP_READ, 24'h00abcd, 16'h10);
            begin
                repeat (2000) @(posedge clk);
                cmp("stall", 24'h1, rq.size() == 0 && flash.nb < 16 && rv === 1'h1);
                rr <= 1'h1;
            end
        join
        cmp("rd_op", 24'h0b, flash.lop);
        cmp("rd_adr", 24'h00abcd, flash.addr);
        cmp("rd_cnt", 24'h10, rq.size());
        for (i = 0; i < 16 && i < rq.size(); i++) cmp("rd_dat", 24'(160 + i), rq[i]);
        results();
    end
    // Watchdog well beyond the expected run length
    initial begin
        #3000000;
        err_total++;
        results();
    end
endmodule
bind bsf_seq bsf_seq_asserts chk (.I_CLK_SYS, .I_SYS_RST, .I_FW_VALID, .I_CMD_VALID,
    .O_CMD_READY, .I_WR_VALID, .O_WR_READY, .O_RD_VALID, .O_RD_DATA, .I_RD_READY,
    .O_BOOT_DONE, .O_BUSY, .O_FLASH_SERIAL_CLOCK, .O_FLASH_SERIAL_CLOCK_OE,
    .O_FLASH_SERIAL_OUT, .O_FLASH_SERIAL_OUT_OE, .O_FLASH_SELECT_PRIMARY_N,
    .O_FLASH_SELECT_PRIMARY_N_OE, .O_FLASH_SELECT_SECONDARY_N);
`default_nettype wire
